// >>> hw/pb_seq_params.svh
// Constants for the pushbutton power sequencer: register map, field spots, timing.
// Assumes a 200 MHz pclk and a 1 ms internal time base.
`ifndef PB_SEQ_PARAMS_SVH
`define PB_SEQ_PARAMS_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define PBS_CLK_PERIOD_NS   5
`define PBS_TIME_BASE_NS    1000000

// ----------------------------------------
// Intervals in time-base ticks (ms)
// ----------------------------------------
`define PBS_MS_STATUS_MIN   13'h0032
`define PBS_MS_POWER_PRESS  13'h0190
`define PBS_MS_SHUTDOWN     13'h03E8
`define PBS_MS_STARTUP      13'h1388
`define PBS_MS_LONG_PRESS   13'h1388
`define PBS_MS_ONE          13'h0001
`define PBS_MS_ZERO         13'h0000
`define PBS_TICK_ONE        18'h0_0001
`define PBS_TICK_ZERO       18'h0_0000

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define PBS_REG_CTRL        8'h00
`define PBS_REG_STATUS      8'h04
`define PBS_CTRL_RESET      32'h0000_0001
`define PBS_CTRL_WAKE_BIT   0
`define PBS_ST_STATE_LSB    0
`define PBS_ST_STATE_MSB    2
`define PBS_ST_BUCK_BIT     4
`define PBS_ST_LDO_BIT      5
`define PBS_ST_DRIVE_BIT    6
`define PBS_ST_BUTTON_BIT   7
`define PBS_WORD_ZERO       32'h0000_0000

`endif

// >>> hw/pb_seq_pkg.sv
// Types for the pushbutton power sequencer.
// Assumes the params header is compiled alongside.
package pb_seq_pkg;

    typedef enum logic [2:0]
    {
        deep_off_state,
        first_startup_state,
        later_startup_state,
        powered_state,
        reset_shutdown_state,
        normal_shutdown_state,
        off_state
    } seq_state_t;

    typedef struct packed
    {
        logic pb_n;
        logic buck_req;
        logic ldo_req;
        logic ext_power;
        logic uvlo;
        logic por;
        logic first_good;
        logic order_sel;
    } pin_in_t;

endpackage

// >>> hw/pushbutton_power_sequencer.sv
// Pushbutton power sequencer: state machine, debounce, regulator ordering, APB regs.
// Assumes asynchronous pins on the sequencer side and an APB master on pclk.
`include "pb_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pushbutton_power_sequencer
    import pb_seq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PBS_TIME_BASE_NS / `PBS_CLK_PERIOD_NS
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        button_n_in,
    input  wire logic        buck_reg_enable_in,
    input  wire logic        linear_reg_enable_in,
    input  wire logic        order_select,
    input  wire logic        ext_power_valid,
    input  wire logic        vout_uvlo,
    input  wire logic        vout_por,
    input  wire logic        first_reg_good,
    output var  logic        buck_enable_out,
    output var  logic        linear_enable_out,
    output var  logic        button_status_out,
    output var  logic        button_status_oe_n
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pin_in_t pins;
    pin_in_t sync1_r;
    pin_in_t sync2_r;
    pin_in_t sync3_r;
    pin_in_t in_r;
    pin_in_t in_nxt;

    assign pins = '{pb_n: button_n_in, buck_req: buck_reg_enable_in, ldo_req: linear_reg_enable_in,
                    ext_power: ext_power_valid, uvlo: vout_uvlo, por: vout_por,
                    first_good: first_reg_good, order_sel: order_select};

    // A bit moves only when stages two and three agree
    always_comb
    begin
        in_nxt = (sync3_r & ~(sync2_r ^ sync3_r)) | (in_r & (sync2_r ^ sync3_r));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= '{pb_n: 1'b1, default: 1'b0};
            sync2_r <= '{pb_n: 1'b1, default: 1'b0};
            sync3_r <= '{pb_n: 1'b1, default: 1'b0};
            in_r    <= '{pb_n: 1'b1, default: 1'b0};
        end
        else
        begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            in_r    <= in_nxt;
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    logic [17:0] tick_cnt_r;
    logic [17:0] tick_cnt_nxt;
    logic        tick;

    assign tick = (tick_cnt_r == 18'(TICK_CYCLES - 1));

    always_comb
    begin
        tick_cnt_nxt = tick ? `PBS_TICK_ZERO : tick_cnt_r + `PBS_TICK_ONE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_r <= `PBS_TICK_ZERO;
        else
            tick_cnt_r <= tick_cnt_nxt;
    end

    // ----------------------------------------
    // Button press tracking
    // ----------------------------------------
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic [12:0] press_ms_r;
    logic [12:0] press_ms_nxt;
    logic        pb_prev_r;
    logic        armed_r;
    logic        armed_nxt;
    logic        lp_valid_r;
    logic        lp_valid_nxt;
    logic        on_state;
    logic        shut_state;
    logic        press_400;
    logic        long_press;
    logic        status_hit;

    assign on_state   = (state_r == first_startup_state) || (state_r == later_startup_state)
                        || (state_r == powered_state);
    assign shut_state = (state_r == normal_shutdown_state) || (state_r == reset_shutdown_state);
    assign press_400  = armed_r && !in_r.pb_n && tick && (press_ms_r == `PBS_MS_POWER_PRESS - `PBS_MS_ONE);
    assign long_press = lp_valid_r && !in_r.pb_n && tick
                        && (press_ms_r == `PBS_MS_LONG_PRESS - `PBS_MS_ONE);
    assign status_hit = on_state && lp_valid_r && !in_r.pb_n && tick
                        && (press_ms_r == `PBS_MS_STATUS_MIN - `PBS_MS_ONE);

    always_comb
    begin
        press_ms_nxt = press_ms_r;
        if (in_r.pb_n)
            press_ms_nxt = `PBS_MS_ZERO;
        else if (tick && press_ms_r < `PBS_MS_LONG_PRESS)
            press_ms_nxt = press_ms_r + `PBS_MS_ONE;
        // Press held into shutdown cannot start power-up until released
        armed_nxt = armed_r;
        if (shut_state)
            armed_nxt = 1'b0;
        else if (in_r.pb_n)
            armed_nxt = 1'b1;
        // Only a press begun while on counts for status or long-press reset
        lp_valid_nxt = lp_valid_r;
        if (in_r.pb_n)
            lp_valid_nxt = 1'b0;
        else if (pb_prev_r && on_state)
            lp_valid_nxt = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            press_ms_r <= `PBS_MS_ZERO;
            pb_prev_r  <= 1'b1;
            armed_r    <= 1'b0;
            lp_valid_r <= 1'b0;
        end
        else
        begin
            press_ms_r <= press_ms_nxt;
            pb_prev_r  <= in_r.pb_n;
            armed_r    <= armed_nxt;
            lp_valid_r <= lp_valid_nxt;
        end
    end

    // ----------------------------------------
    // Registers over APB
    // ----------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] rdata_nxt;
    logic        ready_nxt;
    logic        err_nxt;
    logic        wake_en;
    logic        mapped;
    logic        buck_en_r;
    logic        ldo_en_r;
    logic        drive_r;

    assign wake_en = ctrl_r[`PBS_CTRL_WAKE_BIT];
    assign mapped  = (paddr == `PBS_REG_CTRL) || (paddr == `PBS_REG_STATUS);

    // One wait state: pready rises in the second access cycle
    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = prdata;
        ready_nxt = psel && penable && !pready;
        err_nxt   = ready_nxt && !mapped;
        if (psel && penable && pready && pwrite && paddr == `PBS_REG_CTRL)
            ctrl_nxt = pwdata & `PBS_CTRL_RESET;
        if (ready_nxt && !pwrite)
        begin
            rdata_nxt = `PBS_WORD_ZERO;
            if (paddr == `PBS_REG_CTRL)
                rdata_nxt = ctrl_r;
            else if (paddr == `PBS_REG_STATUS)
            begin
                rdata_nxt[`PBS_ST_STATE_MSB:`PBS_ST_STATE_LSB] = state_r;
                rdata_nxt[`PBS_ST_BUCK_BIT]   = buck_en_r;
                rdata_nxt[`PBS_ST_LDO_BIT]    = ldo_en_r;
                rdata_nxt[`PBS_ST_DRIVE_BIT]  = drive_r;
                rdata_nxt[`PBS_ST_BUTTON_BIT] = in_r.pb_n;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r  <= `PBS_CTRL_RESET;
            prdata  <= `PBS_WORD_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            prdata  <= rdata_nxt;
            pready  <= ready_nxt;
            pslverr <= err_nxt;
        end
    end

    // ----------------------------------------
    // Sequencer state machine
    // ----------------------------------------
    logic [12:0] state_ms_r;
    logic [12:0] state_ms_nxt;
    logic        buck_en_nxt;
    logic        ldo_en_nxt;
    logic        wait_done;
    logic        start_done;
    logic        any_req;

    assign wait_done  = tick && (state_ms_r == `PBS_MS_SHUTDOWN - `PBS_MS_ONE);
    assign start_done = tick && (state_ms_r == `PBS_MS_STARTUP - `PBS_MS_ONE);
    assign any_req    = in_r.buck_req || in_r.ldo_req;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            deep_off_state, off_state:
            begin
                if (long_press)
                    state_nxt = reset_shutdown_state;
                else if (any_req && !in_r.uvlo)
                    state_nxt = powered_state;
                else if (press_400 || (in_r.ext_power && wake_en))
                    state_nxt = (state_r == off_state) ? later_startup_state
                                                       : first_startup_state;
            end
            first_startup_state, later_startup_state:
            begin
                if (start_done)
                    state_nxt = powered_state;
            end
            powered_state:
            begin
                if (long_press)
                    state_nxt = reset_shutdown_state;
                else if (in_r.uvlo || !any_req)
                    state_nxt = normal_shutdown_state;
            end
            normal_shutdown_state:
            begin
                // Inputs other than por ignored until the wait ends
                if (wait_done)
                    state_nxt = off_state;
            end
            reset_shutdown_state:
            begin
                if (wait_done)
                    state_nxt = deep_off_state;
            end
        endcase
        if (in_r.por)
            state_nxt = reset_shutdown_state;
        state_ms_nxt = state_ms_r;
        if (state_nxt != state_r || in_r.por)
            state_ms_nxt = `PBS_MS_ZERO;
        else if (tick && state_ms_r < `PBS_MS_STARTUP)
            state_ms_nxt = state_ms_r + `PBS_MS_ONE;
        // Startup: first regulator at once, second once the first is near regulation
        buck_en_nxt = 1'b0;
        ldo_en_nxt  = 1'b0;
        if (state_nxt == first_startup_state || state_nxt == later_startup_state)
        begin
            buck_en_nxt = !in_r.order_sel || buck_en_r || (ldo_en_r && in_r.first_good);
            ldo_en_nxt  = in_r.order_sel || ldo_en_r || (buck_en_r && in_r.first_good);
        end
        else if (state_nxt == powered_state)
        begin
            buck_en_nxt = in_r.buck_req;
            ldo_en_nxt  = in_r.ldo_req;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= reset_shutdown_state;
            state_ms_r <= `PBS_MS_ZERO;
            buck_en_r  <= 1'b0;
            ldo_en_r   <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            state_ms_r <= state_ms_nxt;
            buck_en_r  <= buck_en_nxt;
            ldo_en_r   <= ldo_en_nxt;
        end
    end

    assign buck_enable_out   = buck_en_r;
    assign linear_enable_out = ldo_en_r;

    // ----------------------------------------
    // Button status pin
    // ----------------------------------------
    logic [12:0] stat_ms_r;
    logic [12:0] stat_ms_nxt;
    logic        drive_nxt;

    always_comb
    begin
        drive_nxt = drive_r;
        if (!on_state)
            drive_nxt = 1'b0;
        else if (status_hit)
            drive_nxt = 1'b1;
        else if (in_r.pb_n && stat_ms_r >= `PBS_MS_STATUS_MIN)
            drive_nxt = 1'b0;
        stat_ms_nxt = stat_ms_r;
        if (!drive_r)
            stat_ms_nxt = `PBS_MS_ZERO;
        else if (tick && stat_ms_r < `PBS_MS_STATUS_MIN)
            stat_ms_nxt = stat_ms_r + `PBS_MS_ONE;
    end

    // Open drain: the pin only ever pulls low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_r            <= 1'b0;
            stat_ms_r          <= `PBS_MS_ZERO;
            button_status_oe_n <= 1'b1;
            button_status_out  <= 1'b0;
        end
        else
        begin
            drive_r            <= drive_nxt;
            stat_ms_r          <= stat_ms_nxt;
            button_status_oe_n <= !drive_nxt;
            button_status_out  <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_wait_end;
        state_r == normal_shutdown_state && wait_done && !in_r.por;
    endsequence

    a_last_enable_down: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == powered_state && !any_req && !long_press && !in_r.por |=> state_r == normal_shutdown_state)
        else $error("powered state did not shut down on enables low");
    a_wait_to_off: assert property (@(posedge pclk) disable iff (!presetn)
        s_wait_end |=> state_r == off_state)
        else $error("shutdown wait did not end in off");
    a_wait_ignores: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == normal_shutdown_state && !wait_done && !in_r.por |=> state_r == normal_shutdown_state)
        else $error("shutdown wait left early");
    a_uvlo_down: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == powered_state && in_r.uvlo && !long_press && !in_r.por
        |=> state_r == normal_shutdown_state && !buck_en_r && !ldo_en_r)
        else $error("undervoltage did not shut both regulators");
    a_por_entry: assert property (@(posedge pclk) disable iff (!presetn)
        in_r.por |=> state_r == reset_shutdown_state && state_ms_r == `PBS_MS_ZERO)
        else $error("power-on reset not honoured");
    a_status_release: assert property (@(posedge pclk) disable iff (!presetn)
        drive_r && !on_state |=> button_status_oe_n)
        else $error("status driven outside on states");
    a_status_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(drive_r) && $past(on_state) |-> $past(stat_ms_r) >= `PBS_MS_STATUS_MIN)
        else $error("status pulse too short");
    a_buck_first: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ldo_en_r) && (state_r == first_startup_state || state_r == later_startup_state)
        && !in_r.order_sel |-> $past(buck_en_r) && $past(in_r.first_good))
        else $error("linear regulator started before buck was good");
    a_ldo_first: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == first_startup_state || state_r == later_startup_state) && $past(in_r.order_sel)
        && $past(state_r) == state_r |-> ldo_en_r)
        else $error("linear regulator not first with order select high");
    a_off_wake: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == off_state && any_req && !in_r.uvlo && !in_r.por && !long_press
        |=> state_r == powered_state)
        else $error("enable input did not wake from off");

endmodule

`default_nettype wire

// >>> dv/pb_host_model.sv
// Pushbutton and host model for the power sequencer.
// Assumes the bench sets press level and the wanted enables.
`timescale 1ns/1ps
`default_nettype none
module pb_host_model
(
    input  wire logic pclk,
    input  wire logic press,
    input  wire logic want_buck,
    input  wire logic want_ldo,
    input  wire logic drop_on_status,
    input  wire logic status_oe_n,
    output var  logic button_n,
    output var  logic buck_req = 1'b0,
    output var  logic ldo_req = 1'b0
);
    logic heard_r = 1'b0;

    // Pull-up returns the button high on release
    always_comb button_n = ~press;

    // Host drops both enables once it sees a status pulse
    always @(posedge pclk)
    begin
        if (!want_buck && !want_ldo)
            heard_r <= 1'b0;
        else if (drop_on_status && status_oe_n === 1'b0)
            heard_r <= 1'b1;
        buck_req <= want_buck && !heard_r;
        ldo_req <= want_ldo && !heard_r;
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Bench for the pushbutton power sequencer.
// Assumes a 4-cycle time base; state is read back over APB.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pb_seq_pkg::*;
    localparam int TK = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, button_n, buck_req, ldo_req, buck_en, lin_en, st_out, st_oe_n;
    logic order_sel = 0, ext = 0, uvlo = 0, por = 0, good = 0;
    logic press = 0, w_buck = 0, w_ldo = 0, drop = 1;
    int fails = 0, checked = 0, t0, d;

    always #2.5 pclk = ~pclk;

    pushbutton_power_sequencer #(.TICK_CYCLES(TK)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_n_in(button_n),
        .buck_reg_enable_in(buck_req), .linear_reg_enable_in(ldo_req), .order_select(order_sel),
        .ext_power_valid(ext), .vout_uvlo(uvlo), .vout_por(por), .first_reg_good(good),
        .buck_enable_out(buck_en), .linear_enable_out(lin_en), .button_status_out(st_out),
        .button_status_oe_n(st_oe_n));

    pb_host_model u_host (.pclk(pclk), .press(press), .want_buck(w_buck), .want_ldo(w_ldo),
        .drop_on_status(drop), .status_oe_n(st_oe_n), .button_n(button_n),
        .buck_req(buck_req), .ldo_req(ldo_req));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic results;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            fails++;
    endtask

    task automatic st(input int s);
        apb(1'b0, 8'h04, 32'h0000_0000);
        cmp(rd[2:0], s);
    endtask

    // Polling bounded by lim cycles
    task automatic wait_st(input int s, input int lim);
        longint t;
        t = $time;
        do apb(1'b0, 8'h04, 32'h0000_0000); while (rd[2:0] !== 3'(s) && $time - t < lim * 5);
        cmp(rd[2:0], s);
    endtask

    task automatic pins(input logic b, input logic l);
        cmp({buck_en, lin_en}, {b, l});
    endtask

    // Poll slack of a few reads either side
    task automatic near(input int from, input int exp);
        int c;
        c = ($time - from) / 5;
        cmp(32'(c > exp - 24 && c < exp + 24), 32'h0000_0001);
    endtask

    initial
    begin
        repeat (95_000) @(posedge pclk);
        fails++;
        results();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(20443));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t0 = $time;
        apb(1'b0, 8'h00, 32'h0000_0000);
        cmp(rd, 32'h0000_0001);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        cmp(32'(err), 32'h0000_0001);
        apb(1'b0, 8'h08, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        cmp(32'(err), 32'h0000_0000);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        apb(1'b0, 8'h00, 32'h0000_0000);
        cmp(rd, 32'h0000_0001);
        wait_st(0, 1100 * TK);
        near(t0, 1000 * TK);
        press <= 1'b1;
        t0 = $time;
        wait_st(1, 500 * TK);
        near(t0, 400 * TK);
        cmp(32'(rd[7:4]), 32'h0000_0001);
        pins(1'b1, 1'b0);
        press <= 1'b0;
        d = $urandom_range(300, 50);
        repeat (d) @(posedge pclk);
        pins(1'b1, 1'b0);
        good <= 1'b1;
        repeat (8) @(posedge pclk);
        pins(1'b1, 1'b1);
        w_buck <= 1'b1;
        w_ldo <= 1'b1;
        wait_st(3, 5200 * TK);
        near(t0, 5400 * TK);
        pins(1'b1, 1'b1);
        press <= 1'b1;
        t0 = $time;
        while (st_oe_n !== 1'b0 && $time - t0 < 100 * TK * 5)
            @(posedge pclk);
        near(t0, 50 * TK);
        cmp(32'({st_out, st_oe_n}), 32'h0000_0000);
        // Shutdown follows the status pulse within a few cycles
        t0 = $time;
        repeat (10 * TK) @(posedge pclk);
        press <= 1'b0;
        wait_st(5, 400);
        pins(1'b0, 1'b0);
        drop <= 1'b0;
        w_buck <= 1'b0;
        w_ldo <= 1'b0;
        press <= 1'b1;
        ext <= 1'b1;
        repeat (4) @(posedge pclk);
        w_buck <= 1'b1;
        repeat (1500) @(posedge pclk);
        st(5);
        pins(1'b0, 1'b0);
        cmp(32'(st_oe_n), 32'h0000_0001);
        w_buck <= 1'b0;
        press <= 1'b0;
        ext <= 1'b0;
        drop <= 1'b1;
        wait_st(6, 3000);
        near(t0, 1000 * TK);
        w_buck <= 1'b1;
        wait_st(3, 200);
        pins(1'b1, 1'b0);
        uvlo <= 1'b1;
        wait_st(5, 100);
        pins(1'b0, 1'b0);
        uvlo <= 1'b0;
        ext <= 1'b1;
        order_sel <= 1'b1;
        good <= 1'b0;
        w_buck <= 1'b0;
        wait_st(2, 1100 * TK);
        pins(1'b0, 1'b1);
        ext <= 1'b0;
        good <= 1'b1;
        repeat (8) @(posedge pclk);
        pins(1'b1, 1'b1);
        w_buck <= 1'b1;
        w_ldo <= 1'b1;
        wait_st(3, 5200 * TK);
        drop <= 1'b0;
        press <= 1'b1;
        repeat (60 * TK) @(posedge pclk);
        press <= 1'b0;
        repeat (30 * TK) @(posedge pclk);
        cmp(32'(st_oe_n), 32'h0000_0000);
        repeat (20 * TK) @(posedge pclk);
        cmp(32'(st_oe_n), 32'h0000_0001);
        press <= 1'b1;
        t0 = $time;
        wait_st(4, 5200 * TK);
        near(t0, 5000 * TK);
        pins(1'b0, 1'b0);
        w_buck <= 1'b0;
        w_ldo <= 1'b0;
        t0 = $time;
        wait_st(0, 1100 * TK);
        near(t0, 1000 * TK);
        repeat (600 * TK) @(posedge pclk);
        st(0);
        press <= 1'b0;
        drop <= 1'b1;
        w_buck <= 1'b1;
        wait_st(3, 200);
        por <= 1'b1;
        wait_st(4, 100);
        pins(1'b0, 1'b0);
        por <= 1'b0;
        w_buck <= 1'b0;
        results();
    end
endmodule
`default_nettype wire
